/* design/hsf_pkg.sv */
// package for the host status flag register block
// assumes one controller clock and a synchronous active-high reset
package hsf_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  STATUS_OFFSET    = 8'h24;
    localparam logic [31:0] STATUS_RESET     = 32'h0000_1000;
    localparam logic [31:0] STATUS_RSVD_MASK = 32'hFFFF_0FC0;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ASYNC_RUN_BIT  = 15;
    localparam int PERIOD_RUN_BIT = 14;
    localparam int RECLAIM_BIT    = 13;
    localparam int HALTED_BIT     = 12;
    localparam int ADVANCE_BIT    = 5;
    localparam int BUS_ERR_BIT    = 4;
    localparam int WRAP_BIT       = 3;
    localparam int PORT_CHG_BIT   = 2;
    localparam int XFER_ERR_BIT   = 1;
    localparam int COMPLETE_BIT   = 0;
    localparam int EVENT_COUNT    = 6;

    // ****************************************
    // frame list size codes and index tap bits
    // ****************************************
    localparam logic [1:0] FLS_1024     = 2'b00;
    localparam logic [1:0] FLS_512      = 2'b01;
    localparam logic [1:0] FLS_256      = 2'b10;
    localparam int         TAP_1024_BIT = 13;
    localparam int         TAP_512_BIT  = 12;
    localparam int         TAP_256_BIT  = 11;
    localparam int         INDEX_WIDTH  = 14;

endpackage : hsf_pkg

/* design/hsf_sticky_flag.sv */
// one write-one-to-clear event flag
// assumes set and clear pulses are synchronous to clk_i
`timescale 1ns/100ps
module hsf_sticky_flag (
    input  wire logic clk_i,    // controller clock
    input  wire logic rst_i,    // synchronous reset
    input  wire logic set_i,    // hardware event
    input  wire logic clear_i,  // software writes one
    input  wire logic load_i,   // power-state reload strobe
    input  wire logic load_val_i, // value used on reload
    output logic      flag_o    // sticky flag
);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flag_o <= 1'b0;
        else if (load_i)
            flag_o <= load_val_i | set_i;
        else if (set_i)
            flag_o <= 1'b1;   // set beats a same-cycle clear [R21]
        else if (clear_i)
            flag_o <= 1'b0;   // [R21]
    end
endmodule : hsf_sticky_flag

/* design/hsf_status_flags.sv */
// host status flag register with schedule and halt tracking
// assumes the schedule engines, port logic and command register drive its inputs
`timescale 1ns/100ps
// What this block does
// [R1] bit 15 shows whether the asynchronous schedule really runs; resets 0
// [R2] asynchronous status follows its enable only once the change is done
// [R3] bit 14 shows whether the periodic schedule really runs; resets 0
// [R4] periodic status changes only after the schedule truly started or stopped
// [R5] bit 13 is read-only, resets 0, shows empty asynchronous schedule detection
// [R6] halted resets to 1 and reads 0 while run control is 1
// [R7] halted set only once execution has stopped after run control fell
// [R8] after doorbell, set async advance flag on next schedule advance
// [R9] set host bus error flag on parity error, master or target abort
// [R10] host bus error also clears the run control bit
// [R11] set frame wrap flag when the frame index wraps to zero
// [R12] with 1024 entries, set wrap flag on each toggle of index bit 13
// [R13] with 512 entries, set wrap flag on each toggle of index bit 12
// [R14] set port change on owned-port change rise or resume after J-K
// [R15] on return to full power, port change loads OR of port changes
// [R16] set transaction error flag when a transaction ends in error
// [R17] an erroring descriptor asking interrupt sets both error and completion
// [R18] set completion flag when a descriptor with interrupt request retires
// [R19] also set completion flag on a short packet
// [R20] software writes zero to reserved bits
// [R21] event flags clear by writing one; software acknowledges that way
// [R22] pipeline drains before halted may be raised
// [R23] interrupt raised when a flag and its enable are both set
// [R24] writes to status bits and zero writes to flags change nothing
module hsf_status_flags (
    input  wire logic        ref_clk_i,           // controller clock
    input  wire logic        rst_i,               // synchronous reset
    input  wire logic [7:0]  reg_addr_i,          // register offset
    input  wire logic        reg_wr_i,            // write strobe
    input  wire logic [31:0] reg_wdata_i,         // write data
    input  wire logic        reg_rd_i,            // read strobe
    output logic      [31:0] reg_rdata_o,         // read data
    input  wire logic        run_control_i,       // command run bit
    input  wire logic        async_sched_enable_i, // command async enable
    input  wire logic        periodic_sched_enable_i, // command periodic enable
    input  wire logic        async_advance_doorbell_i, // doorbell pending
    input  wire logic [1:0]  frame_list_size_i,   // frame list size code
    input  wire logic [13:0] frame_index_counter_i, // frame index
    input  wire logic        async_running_i,     // async engine active
    input  wire logic        periodic_running_i,  // periodic engine active
    input  wire logic        async_advanced_i,    // async schedule advanced
    input  wire logic        reclaim_i,           // empty async schedule seen
    input  wire logic        pipeline_busy_i,     // transactions in flight
    input  wire logic        bus_error_i,         // parity or abort pulse
    input  wire logic        port_change_rise_i,  // change on owned port rose
    input  wire logic        resume_rise_i,       // resume after J-K rose
    input  wire logic        power_restore_i,     // return to full power pulse
    input  wire logic        port_change_any_i,   // OR of port change bits
    input  wire logic        xfer_error_i,        // transaction error pulse
    input  wire logic        xfer_done_ioc_i,     // retired with interrupt request
    input  wire logic        short_packet_i,      // short packet pulse
    input  wire logic [5:0]  intr_enable_i,       // interrupt enable bits
    output logic             clear_run_o,         // pulse: clear run control
    output logic             intr_o               // interrupt request
);

    // ****************************************
    // state tracking
    // ****************************************
    typedef enum logic [2:0] {
        HSF_HALTED   = 3'b001,
        HSF_RUNNING  = 3'b010,
        HSF_DRAINING = 3'b100
    } hsf_run_t;

    hsf_run_t    run_reg;
    logic        async_run_reg;
    logic        period_run_reg;
    logic        reclaim_reg;
    logic        halted_reg;
    logic [hsf_pkg::INDEX_WIDTH-1:0] index_prev_reg;
    logic [hsf_pkg::INDEX_WIDTH-1:0] index_toggle;
    logic        doorbell_armed_reg;
    logic [5:0]  flags;
    logic [5:0]  set_vec;
    logic [5:0]  clr_vec;
    logic        wr_hit;
    logic        wrap_tap;
    logic        wrap_evt;

    assign wr_hit = reg_wr_i && (reg_addr_i == hsf_pkg::STATUS_OFFSET);
    // reserved and read-only bits of the write are ignored [R24]
    assign clr_vec = wr_hit ? reg_wdata_i[5:0] : 6'h00;

    // ****************************************
    // run and halt
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            run_reg <= HSF_HALTED;
        else
        begin
            unique case (run_reg)
                HSF_HALTED:
                    if (run_control_i && !bus_error_i)
                        run_reg <= HSF_RUNNING;
                HSF_RUNNING:
                    if (!run_control_i || bus_error_i)
                        run_reg <= HSF_DRAINING;   // [R7]
                HSF_DRAINING:
                    if (!pipeline_busy_i)
                        run_reg <= HSF_HALTED;     // [R22]
                default:
                    run_reg <= HSF_HALTED;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            halted_reg <= 1'b1;                  // [R6]
        else if (run_control_i && !bus_error_i)
            halted_reg <= 1'b0;                  // [R6]
        else if (run_reg == HSF_DRAINING && !pipeline_busy_i)
            halted_reg <= 1'b1;                  // [R7] [R22]
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            clear_run_o <= 1'b0;
        else
            clear_run_o <= bus_error_i;          // [R10]
    end

    // ****************************************
    // schedule status, reclaim
    // ****************************************
    // engines report their real state, so status lags enable until done
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            async_run_reg  <= 1'b0;              // [R1]
            period_run_reg <= 1'b0;              // [R3]
        end
        else
        begin
            async_run_reg  <= async_running_i;   // [R1] [R2]
            period_run_reg <= periodic_running_i; // [R3] [R4]
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            reclaim_reg <= 1'b0;
        else
            reclaim_reg <= reclaim_i;            // [R5]
    end

    // ****************************************
    // event sources
    // ****************************************
    always_comb
    begin
        unique case (frame_list_size_i)
            hsf_pkg::FLS_1024: wrap_tap = index_toggle[hsf_pkg::TAP_1024_BIT]; // [R12]
            hsf_pkg::FLS_512:  wrap_tap = index_toggle[hsf_pkg::TAP_512_BIT];  // [R13]
            hsf_pkg::FLS_256:  wrap_tap = index_toggle[hsf_pkg::TAP_256_BIT];
            default:           wrap_tap = index_toggle[hsf_pkg::TAP_1024_BIT];
        endcase
    end

    // the same index bit is compared across one cycle, so a size change cannot fake a wrap
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            index_prev_reg <= 14'h0000;
        else
            index_prev_reg <= frame_index_counter_i;
    end

    assign index_toggle = frame_index_counter_i ^ index_prev_reg;
    assign wrap_evt     = wrap_tap;   // [R11]

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            doorbell_armed_reg <= 1'b0;
        else if (async_advance_doorbell_i)
            doorbell_armed_reg <= 1'b1;   // a ring during an advance stays armed for the next
        else if (async_advanced_i)
            doorbell_armed_reg <= 1'b0;
    end

    always_comb
    begin
        set_vec = 6'h00;
        set_vec[hsf_pkg::ADVANCE_BIT]  = doorbell_armed_reg && async_advanced_i;   // [R8]
        set_vec[hsf_pkg::BUS_ERR_BIT]  = bus_error_i;                              // [R9]
        set_vec[hsf_pkg::WRAP_BIT]     = wrap_evt;                                 // [R11]
        set_vec[hsf_pkg::PORT_CHG_BIT] = port_change_rise_i || resume_rise_i;      // [R14]
        set_vec[hsf_pkg::XFER_ERR_BIT] = xfer_error_i;                             // [R16]
        set_vec[hsf_pkg::COMPLETE_BIT] = xfer_done_ioc_i || short_packet_i;        // [R17] [R18] [R19]
    end

    // ****************************************
    // sticky flags
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < hsf_pkg::EVENT_COUNT; g++)
        begin : g_flag
            hsf_sticky_flag u_flag (
                .clk_i      (ref_clk_i),
                .rst_i      (rst_i),
                .set_i      (set_vec[g]),
                .clear_i    (clr_vec[g]),   // [R21]
                .load_i     ((g == hsf_pkg::PORT_CHG_BIT) ? power_restore_i : 1'b0),      // [R15]
                .load_val_i ((g == hsf_pkg::PORT_CHG_BIT) ? port_change_any_i : 1'b0),
                .flag_o     (flags[g])
            );
        end
    endgenerate

    // ****************************************
    // read and interrupt
    // ****************************************
    // reserved bits read zero; software keeps them zero on writes [R20]
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i && reg_addr_i == hsf_pkg::STATUS_OFFSET)
            reg_rdata_o <= {16'h0000, async_run_reg, period_run_reg, reclaim_reg, halted_reg,
                            6'h00, flags};
        else
            reg_rdata_o <= 32'h0000_0000;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            intr_o <= 1'b0;
        else
            intr_o <= |(flags & intr_enable_i);  // [R23]
    end

    // ****************************************
    // checks
    // ****************************************
    property p_halt_reset;
        @(posedge ref_clk_i) $fell(rst_i) |-> halted_reg;
    endproperty
    a_halt_reset: assert property (p_halt_reset) else $error("halted not set after reset"); // [R6]

    property p_halt_run;
        @(posedge ref_clk_i) disable iff (rst_i)
        (run_control_i && !bus_error_i) |=> !halted_reg;
    endproperty
    a_halt_run: assert property (p_halt_run) else $error("halted while running"); // [R6]

    property p_halt_drain;
        @(posedge ref_clk_i) disable iff (rst_i)
        (run_reg == HSF_DRAINING && pipeline_busy_i) |=> !$rose(halted_reg);
    endproperty
    a_halt_drain: assert property (p_halt_drain) else $error("halted before drain"); // [R22]

    sequence s_ring;
        doorbell_armed_reg && async_advanced_i;
    endsequence
    property p_advance;
        @(posedge ref_clk_i) disable iff (rst_i) s_ring |=> flags[hsf_pkg::ADVANCE_BIT];
    endproperty
    a_advance: assert property (p_advance) else $error("advance flag missed"); // [R8]

    property p_bus_err;
        @(posedge ref_clk_i) disable iff (rst_i)
        bus_error_i |=> flags[hsf_pkg::BUS_ERR_BIT] && clear_run_o;
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error not handled"); // [R9] [R10]

    property p_wrap;
        @(posedge ref_clk_i) disable iff (rst_i) wrap_evt |=> flags[hsf_pkg::WRAP_BIT];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag missed"); // [R11]

    property p_complete;
        @(posedge ref_clk_i) disable iff (rst_i)
        (xfer_done_ioc_i || short_packet_i) |=> flags[hsf_pkg::COMPLETE_BIT];
    endproperty
    a_complete: assert property (p_complete) else $error("completion flag missed"); // [R18] [R19]

    property p_zero_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!power_restore_i && wr_hit && reg_wdata_i[5:0] == 6'h00) |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write cleared a flag"); // [R24]

    property p_clear;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_hit && reg_wdata_i[hsf_pkg::XFER_ERR_BIT] && !xfer_error_i) |=> !flags[hsf_pkg::XFER_ERR_BIT];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear"); // [R21]

    property p_intr;
        @(posedge ref_clk_i) disable iff (rst_i) (|(flags & intr_enable_i)) |=> intr_o;
    endproperty
    a_intr: assert property (p_intr) else $error("interrupt missed"); // [R23]

    property p_reset_values;
        @(posedge ref_clk_i) $fell(rst_i)
        |-> !async_run_reg && !period_run_reg && !reclaim_reg && flags == 6'h00;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("status not cleared by reset"); // [R1] [R3] [R5]

    sequence s_drained;
        run_reg == HSF_DRAINING && !pipeline_busy_i && !run_control_i;
    endsequence
    property p_halt_set;
        @(posedge ref_clk_i) disable iff (rst_i) s_drained |=> halted_reg;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("halted not raised after drain"); // [R7] [R22]

    property p_port_change;
        @(posedge ref_clk_i) disable iff (rst_i)
        (port_change_rise_i || resume_rise_i) |=> flags[hsf_pkg::PORT_CHG_BIT];
    endproperty
    a_port_change: assert property (p_port_change) else $error("port change flag missed"); // [R14]

    property p_restore;
        @(posedge ref_clk_i) disable iff (rst_i)
        power_restore_i |=> flags[hsf_pkg::PORT_CHG_BIT] ==
            ($past(port_change_any_i) || $past(port_change_rise_i) || $past(resume_rise_i));
    endproperty
    a_restore: assert property (p_restore) else $error("port change reload wrong"); // [R15]

    property p_xfer_err;
        @(posedge ref_clk_i) disable iff (rst_i) xfer_error_i |=> flags[hsf_pkg::XFER_ERR_BIT];
    endproperty
    a_xfer_err: assert property (p_xfer_err) else $error("transaction error flag missed"); // [R16]

    property p_err_with_ioc;
        @(posedge ref_clk_i) disable iff (rst_i)
        (xfer_error_i && xfer_done_ioc_i) |=> flags[hsf_pkg::XFER_ERR_BIT] && flags[hsf_pkg::COMPLETE_BIT];
    endproperty
    a_err_with_ioc: assert property (p_err_with_ioc) else $error("error with completion not both set"); // [R17]

    property p_clear_run;
        @(posedge ref_clk_i) disable iff (rst_i) clear_run_o |-> $past(bus_error_i);
    endproperty
    a_clear_run: assert property (p_clear_run) else $error("run clear without bus error"); // [R10]

endmodule : hsf_status_flags

/* verification/hc_status_flags_test.sv */
// self-checking bench for the host status flag register
// assumes the package constants of hsf_pkg; drives every input itself
`timescale 1ns/100ps
module hc_status_flags_test;
    logic        ref_clk_i;
    logic        rst_i;
    logic [7:0]  reg_addr_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_wdata_i;
    logic [31:0] reg_rdata_o;
    logic        run_i;
    logic        async_en;
    logic        per_en;
    logic [1:0]  frame_list_size;
    logic [13:0] fidx;
    logic        a_run;
    logic        p_run;
    logic        reclaim_flag;
    logic        busy;
    logic        any_chg;
    logic [9:0]  ev;          // one-cycle event pulses, see port map
    logic [5:0]  en;
    logic        clear_run_o;
    logic        intr_o;
    logic [31:0] seed = 32'h0000_C7A3;
    logic [31:0] d;
    logic        crun;
    int          failures = 0;
    int          n_tests  = 0;
    localparam logic [31:0] HALT = 32'h0000_1000;

    hsf_status_flags dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .run_control_i(run_i),
        .async_sched_enable_i(async_en), .periodic_sched_enable_i(per_en), .async_advance_doorbell_i(ev[7]),
        .frame_list_size_i(frame_list_size), .frame_index_counter_i(fidx), .async_running_i(a_run),
        .periodic_running_i(p_run), .async_advanced_i(ev[6]), .reclaim_i(reclaim_flag), .pipeline_busy_i(busy),
        .bus_error_i(ev[0]), .port_change_rise_i(ev[1]), .resume_rise_i(ev[2]), .power_restore_i(ev[8]),
        .port_change_any_i(any_chg), .xfer_error_i(ev[3]), .xfer_done_ioc_i(ev[4]), .short_packet_i(ev[5]),
        .intr_enable_i(en), .clear_run_o(clear_run_o), .intr_o(intr_o));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // flag position set by each event pulse of ev[5:0]
    function automatic int ev_bit(input int i);
        int b [6];
        b = '{hsf_pkg::BUS_ERR_BIT, hsf_pkg::PORT_CHG_BIT, hsf_pkg::PORT_CHG_BIT,
              hsf_pkg::XFER_ERR_BIT, hsf_pkg::COMPLETE_BIT, hsf_pkg::COMPLETE_BIT};
        return b[i];
    endfunction : ev_bit

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        @(negedge ref_clk_i);
        d = reg_rdata_o;
        @(posedge ref_clk_i);
    endtask : rd

    task automatic wr(input logic [31:0] v);
        @(posedge ref_clk_i);
        reg_addr_i  <= hsf_pkg::STATUS_OFFSET;
        reg_wdata_i <= v & ~hsf_pkg::STATUS_RSVD_MASK;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic pulse(input logic [9:0] m);
        @(posedge ref_clk_i);
        ev <= m;
        @(posedge ref_clk_i);
        ev <= '0;
        @(negedge ref_clk_i);
        crun = clear_run_o;
        @(posedge ref_clk_i);
    endtask : pulse

    task automatic status(input string nm, input logic [31:0] e);
        rd(hsf_pkg::STATUS_OFFSET);
        check(nm, d, e);
    endtask : status

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // ****************************************
    // clock, reset and watchdog
    // ****************************************
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        failures++; // hang counts as a mismatch
        print_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {reg_addr_i, reg_wr_i, reg_rd_i, reg_wdata_i, run_i, async_en, per_en} = '0;
        {frame_list_size, fidx, a_run, p_run, reclaim_flag, busy, any_chg, ev, en} = '0;
        rst_i = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        status("reset value", hsf_pkg::STATUS_RESET);
        @(negedge ref_clk_i);
        check("intr after reset", {31'h0, intr_o}, 32'h0);
        rd(8'h28);
        check("unmapped read", d, 32'h0);
        $display("test reset done");

        run_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        status("running", 32'h0);
        busy  <= 1'b1;
        run_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        status("draining", 32'h0);
        busy <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        status("halted", HALT);
        $display("test halt done");

        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            {a_run, p_run, reclaim_flag, async_en, per_en} <= seed[4:0];
            repeat (2) @(posedge ref_clk_i);
            status("schedule copy", {16'h0, seed[4:2], 13'h1000});
            wr(32'h0000_F000);
            status("read-only write", {16'h0, seed[4:2], 13'h1000});
        end
        {a_run, p_run, reclaim_flag} <= 3'b000;
        $display("test schedule status done");

        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            en <= seed[5:0];
            pulse(10'h001 << i);
            check("clear run pulse", {31'h0, crun}, {31'h0, i == 0});
            @(negedge ref_clk_i);
            check("interrupt", {31'h0, intr_o}, {31'h0, seed[ev_bit(i)]});
            status("event flag", HALT | (32'h1 << ev_bit(i)));
            wr(32'h0000_0000);
            status("zero write", HALT | (32'h1 << ev_bit(i)));
            wr(32'h1 << ev_bit(i));
            status("one clears", HALT);
        end
        en <= '0;
        pulse(10'h018);
        status("error with completion", HALT | 32'h0000_0003);
        wr(32'h0000_0003);
        $display("test events done");

        pulse(10'h040);
        status("advance unarmed", HALT);
        pulse(10'h080);
        pulse(10'h040);
        status("advance armed", HALT | 32'h0000_0020);
        wr(32'h0000_0020);
        pulse(10'h040);
        status("advance disarmed", HALT);
        $display("test doorbell done");

        for (int k = 0; k < 5; k++)
        begin
            logic [1:0] c [5];
            int         t [5];
            logic       e [5];
            c = '{hsf_pkg::FLS_1024, hsf_pkg::FLS_1024, hsf_pkg::FLS_512, hsf_pkg::FLS_512, hsf_pkg::FLS_256};
            t = '{12, 13, 13, 12, 11};
            e = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            frame_list_size <= c[k];
            repeat (2) @(posedge ref_clk_i);
            fidx <= fidx ^ (14'h1 << t[k]);
            repeat (2) @(posedge ref_clk_i);
            status("frame wrap", HALT | {28'h0, e[k], 3'b000});
            wr(32'h0000_0008);
        end
        $display("test frame wrap done");

        any_chg <= 1'b1;
        pulse(10'h100);
        status("power restore set", HALT | 32'h0000_0004);
        // flag is still set, so a reload with no change pending must clear it
        any_chg <= 1'b0;
        pulse(10'h100);
        status("power restore clear", HALT);
        $display("test power restore done");
        print_verdict();
    end
endmodule : hc_status_flags_test
